/* design/deb_params.svh */
// constants for the dsp external bus and control pin block
// assumes inclusion by deb_top and tb, after the package
`ifndef DEB_PARAMS_SVH
`define DEB_PARAMS_SVH

// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define DEB_AW         8
`define DEB_OFF_CTRL   8'h00
`define DEB_OFF_STAT   8'h04
`define DEB_OFF_CMD    8'h08
`define DEB_OFF_PC     8'h0C

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define DEB_CTRL_WS    0
`define DEB_CTRL_SHR   1
`define DEB_ST_UOUT    0
`define DEB_ST_UIN     2
`define DEB_ST_BUSY    4
`define DEB_ST_HALT    5
`define DEB_ST_PEND    6
`define DEB_CMD_DATA   0
`define DEB_CMD_ADDR   16
`define DEB_CMD_RD     19
`define DEB_CMDR_BUSY  16
`define DEB_PCR_STK    16

// ---------------------------------------------------------------
// values
// ---------------------------------------------------------------
`define DEB_RESP_OKAY  2'h0
`define DEB_RESP_SLV   2'h2
`define DEB_PC_W       12
`define DEB_STK_N      6
`define DEB_VEC_IRQ0   12'hFFF
`define DEB_VEC_IRQ1   12'hFFE
`define DEB_VEC_IRQ2   12'hFFD
`define DEB_VEC_RST    12'hFFC
`define DEB_SLOT_SHR   3'h4
`define DEB_SLOT_RSVD  3'h7
`define DEB_WS_CYC     1'h1

`endif

/* design/deb_pkg.sv */
// types for the dsp external bus and control pin block
// assumes nothing beyond a systemverilog compiler
package deb_pkg;

  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {BUS_IDLE, BUS_INT, BUS_ACC} deb_bus_e;
  typedef enum logic [1:0] {CORE_BOOT, CORE_LOAD, CORE_RUN} deb_core_e;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        rd;
    logic [2:0]  addr;
    logic [15:0] data;
  } deb_cmd_s;

  typedef struct packed {
    logic [1:0] uin;
    logic       halt;
    logic [2:0] irq;
  } deb_sync_s;

endpackage

/* design/deb_top.sv */
// external register bus, vectored interrupts, halt, reset fetch
// and user pins of a small dsp core, with an axi4-lite slave
// assumes one clock, pins synchronous, tri-state resolved outside
//
// Behaviour
// - address bus driven on every register access
// - address lines select one of eight registers
// - slots 0-3 user, 4-6 shared, 7 reserved
// - data lines float except external writes
// - strobe only for outside peripherals
// - write data driven when select and strobe low
// - sampled wait extends the access
// - wait state bit adds exactly one wait
// - halt holds program counter, executes no-ops
// - interrupts raised on rising input edges
// - vectors fetched from fixed words
// - request zero first, request two last
// - reset pushes counter, fetch from 0FFCH
// - status register cleared on reset
// - program counter and stack kept across reset
// - execution starts fixed cycles after release
// - user inputs for branches and status
// - user outputs from writable status bits
// - user output pins are inverted bits
`timescale 1ns/100ps
`include "deb_params.svh"
module deb_top
  import deb_pkg::*;
(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 ce,
  input  wire logic [`DEB_AW-1:0]   s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [`DEB_AW-1:0]   s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output logic [2:0]                ext_reg_addr,
  output logic                      ext_rd_wr,
  output logic                      data_strobe_n,
  output logic [15:0]               ext_data_out,
  input  wire logic [15:0]          ext_data_in,
  output logic                      ext_data_oe_n,
  input  wire logic                 ext_wait,
  input  wire logic                 halt,
  input  wire logic                 irq_high_prio,
  input  wire logic                 irq_mid_prio,
  input  wire logic                 irq_low_prio,
  input  wire logic                 user_in_zero,
  input  wire logic                 user_in_one,
  output logic                      user_out_zero,
  output logic                      user_out_one,
  output logic [1:0]                branch_cond,
  output logic [`DEB_PC_W-1:0]      prog_addr,
  output logic                      prog_rd,
  input  wire logic [`DEB_PC_W-1:0] prog_data
);

  deb_sync_s           sync1_q;
  deb_sync_s           sync2_q;
  deb_sync_s           sync3_q;
  logic [2:0]          irq_rise;
  logic [2:0]          pend_q;
  logic [2:0]          take_mask;
  logic [`DEB_PC_W-1:0] take_vec;
  logic                take;
  deb_core_e           core_st_q;
  logic [`DEB_PC_W-1:0] pc_q;
  logic [`DEB_PC_W-1:0] stk_q [`DEB_STK_N];
  logic                in_rst_q;
  logic                aw_hold_q;
  logic                w_hold_q;
  logic [`DEB_AW-1:0]  aw_addr_q;
  logic [31:0]         w_data_q;
  logic [3:0]          w_strb_q;
  logic                bvalid_q;
  logic [1:0]          bresp_q;
  logic                rvalid_q;
  logic [31:0]         rdata_q;
  logic [1:0]          rresp_q;
  logic                wr_fire;
  logic                wr_err;
  logic                wr_ctrl;
  logic                wr_stat;
  logic                wr_cmd;
  logic                cmd_go;
  deb_cmd_s            cmd_w;
  logic                ext_hit;
  logic                ctrl_ws_q;
  logic                ctrl_shr_q;
  logic [1:0]          uout_q;
  logic [31:0]         stat_v;
  logic [31:0]         rd_mux;
  logic                rd_map;
  deb_bus_e            bus_st_q;
  logic                ws_cnt_q;
  logic [15:0]         rd_data_q;

  // ---------------------------------------------------------------
  // input synchronisers and edge detect
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else if (ce) begin
      sync1_q <= {user_in_one, user_in_zero, halt,
                  irq_low_prio, irq_mid_prio, irq_high_prio};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  assign irq_rise    = sync2_q.irq & ~sync3_q.irq;
  assign branch_cond = sync2_q.uin;

  // ---------------------------------------------------------------
  // interrupt pending and priority
  // ---------------------------------------------------------------
  always_comb begin
    take_mask = 3'h0;
    take_vec  = `DEB_VEC_IRQ0;
    if (pend_q[0]) begin
      take_mask = 3'h1;
      take_vec  = `DEB_VEC_IRQ0;
    end else if (pend_q[1]) begin
      take_mask = 3'h2;
      take_vec  = `DEB_VEC_IRQ1;
    end else if (pend_q[2]) begin
      take_mask = 3'h4;
      take_vec  = `DEB_VEC_IRQ2;
    end
  end

  assign take = ce && (core_st_q == CORE_RUN) && !sync2_q.halt
                && (pend_q != 3'h0);

  // a new edge wins over the clear of a taken request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_q <= 3'h0;
    end else if (ce) begin
      pend_q <= (pend_q & ~(take ? take_mask : 3'h0)) | irq_rise;
    end
  end

  // ---------------------------------------------------------------
  // program counter, vector fetch and stack
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_st_q <= CORE_BOOT;
      prog_rd   <= 1'b0;
      prog_addr <= `DEB_VEC_RST;
    end else if (ce) begin
      case (core_st_q)
        CORE_BOOT: begin
          prog_rd   <= 1'b1;
          prog_addr <= `DEB_VEC_RST;
          core_st_q <= CORE_LOAD;
        end
        CORE_LOAD: begin
          prog_rd   <= 1'b0;
          core_st_q <= CORE_RUN;
        end
        CORE_RUN: begin
          if (take) begin
            prog_rd   <= 1'b1;
            prog_addr <= take_vec;
            core_st_q <= CORE_LOAD;
          end
        end
        default: begin
          core_st_q <= CORE_BOOT;
        end
      endcase
    end
  end

  // counter is not reset: it keeps its value for the push
  always_ff @(posedge aclk) begin
    if (aresetn && ce) begin
      case (core_st_q)
        CORE_LOAD: begin
          pc_q <= prog_data;
        end
        CORE_RUN: begin
          if (!take && !sync2_q.halt) begin
            pc_q <= pc_q + 12'h1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_rst_q <= 1'b1;
    end else if (ce) begin
      in_rst_q <= 1'b0;
    end
  end

  // stack is never cleared, one push on reset entry
  always_ff @(posedge aclk) begin
    if ((!aresetn && !in_rst_q) || (aresetn && take)) begin
      stk_q[0] <= pc_q;
      for (int i = 1; i < `DEB_STK_N; i++) begin
        stk_q[i] <= stk_q[i-1];
      end
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite write channel
  // ---------------------------------------------------------------
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready  = !w_hold_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
  assign wr_ctrl = wr_fire && (aw_addr_q == `DEB_OFF_CTRL) && w_strb_q[0];
  assign wr_stat = wr_fire && (aw_addr_q == `DEB_OFF_STAT) && w_strb_q[0];
  assign wr_cmd  = wr_fire && (aw_addr_q == `DEB_OFF_CMD)
                   && (w_strb_q[2:0] == 3'h7);
  assign cmd_go  = wr_cmd && (bus_st_q == BUS_IDLE);
  assign wr_err  = !((aw_addr_q == `DEB_OFF_CTRL)
                   || (aw_addr_q == `DEB_OFF_STAT)
                   || (aw_addr_q == `DEB_OFF_CMD))
                   || (wr_cmd && (bus_st_q != BUS_IDLE));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `DEB_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_err ? `DEB_RESP_SLV : `DEB_RESP_OKAY;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // control and status registers
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ws_q  <= 1'b0;
      ctrl_shr_q <= 1'b0;
      uout_q     <= 2'h0;
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl_ws_q  <= w_data_q[`DEB_CTRL_WS];
        ctrl_shr_q <= w_data_q[`DEB_CTRL_SHR];
      end
      if (wr_stat) begin
        uout_q <= w_data_q[`DEB_ST_UOUT +: 2];
      end
    end
  end

  assign user_out_zero = ~uout_q[0];
  assign user_out_one  = ~uout_q[1];

  always_comb begin
    stat_v = '0;
    stat_v[`DEB_ST_UOUT +: 2] = uout_q;
    stat_v[`DEB_ST_UIN +: 2]  = sync2_q.uin;
    stat_v[`DEB_ST_BUSY]      = (bus_st_q != BUS_IDLE);
    stat_v[`DEB_ST_HALT]      = sync2_q.halt;
    stat_v[`DEB_ST_PEND +: 3] = pend_q;
  end

  // ---------------------------------------------------------------
  // axi4-lite read channel
  // ---------------------------------------------------------------
  always_comb begin
    rd_mux = '0;
    rd_map = 1'b1;
    case (s_axi_araddr)
      `DEB_OFF_CTRL: begin
        rd_mux[`DEB_CTRL_WS]  = ctrl_ws_q;
        rd_mux[`DEB_CTRL_SHR] = ctrl_shr_q;
      end
      `DEB_OFF_STAT: begin
        rd_mux = stat_v;
      end
      `DEB_OFF_CMD: begin
        rd_mux[15:0]           = rd_data_q;
        rd_mux[`DEB_CMDR_BUSY] = (bus_st_q != BUS_IDLE);
      end
      `DEB_OFF_PC: begin
        rd_mux[`DEB_PC_W-1:0]             = pc_q;
        rd_mux[`DEB_PCR_STK +: `DEB_PC_W] = stk_q[0];
      end
      default: begin
        rd_map = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= `DEB_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && !rvalid_q) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_mux;
        rresp_q  <= rd_map ? `DEB_RESP_OKAY : `DEB_RESP_SLV;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // external register bus
  // ---------------------------------------------------------------
  assign cmd_w.rd   = w_data_q[`DEB_CMD_RD];
  assign cmd_w.addr = w_data_q[`DEB_CMD_ADDR +: 3];
  assign cmd_w.data = w_data_q[`DEB_CMD_DATA +: 16];
  // shared slots go out only with their internal units disabled
  assign ext_hit = (cmd_w.addr < `DEB_SLOT_SHR)
                   || (ctrl_shr_q && (cmd_w.addr != `DEB_SLOT_RSVD));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_st_q      <= BUS_IDLE;
      ext_reg_addr  <= 3'h0;
      ext_rd_wr     <= 1'b1;
      data_strobe_n <= 1'b1;
      ext_data_oe_n <= 1'b1;
      ext_data_out  <= 16'h0000;
      ws_cnt_q      <= 1'b0;
      rd_data_q     <= 16'h0000;
    end else if (ce) begin
      case (bus_st_q)
        BUS_IDLE: begin
          if (cmd_go) begin
            ext_reg_addr <= cmd_w.addr;
            ext_rd_wr    <= cmd_w.rd;
            if (ext_hit) begin
              data_strobe_n <= 1'b0;
              ext_data_oe_n <= cmd_w.rd;
              ext_data_out  <= cmd_w.data;
              ws_cnt_q      <= ctrl_ws_q ? `DEB_WS_CYC : 1'b0;
              bus_st_q      <= BUS_ACC;
            end else begin
              bus_st_q <= BUS_INT;
            end
          end
        end
        BUS_INT: begin
          if (ext_rd_wr) begin
            rd_data_q <= 16'h0000;
          end
          ext_rd_wr <= 1'b1;
          bus_st_q  <= BUS_IDLE;
        end
        BUS_ACC: begin
          if (ws_cnt_q) begin
            ws_cnt_q <= 1'b0;
          end else if (!ext_wait) begin
            if (ext_rd_wr) begin
              rd_data_q <= ext_data_in;
            end
            data_strobe_n <= 1'b1;
            ext_data_oe_n <= 1'b1;
            ext_rd_wr     <= 1'b1;
            bus_st_q      <= BUS_IDLE;
          end
        end
        default: begin
          bus_st_q <= BUS_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  addr_stable_a: assert property (
    (bus_st_q == BUS_ACC) && ($past(bus_st_q) == BUS_ACC)
    |-> $stable(ext_reg_addr) && $stable(ext_rd_wr))
    else $error("address or select moved during access");
  data_float_a: assert property (
    (bus_st_q != BUS_ACC) |-> ext_data_oe_n)
    else $error("data bus driven outside external access");
  write_drive_a: assert property (
    !ext_data_oe_n |-> !ext_rd_wr && !data_strobe_n)
    else $error("data driven without write strobe");
  strobe_slot_a: assert property (
    !data_strobe_n |-> (ext_reg_addr != `DEB_SLOT_RSVD))
    else $error("strobe on reserved slot");
  one_wait_a: assert property (
    (cmd_go && ext_hit && ctrl_ws_q && ce) ##1 ce |=> !data_strobe_n)
    else $error("wait state not inserted");
  wait_extend_a: assert property (
    (bus_st_q == BUS_ACC) && !ws_cnt_q && ext_wait
    |=> !data_strobe_n && (bus_st_q == BUS_ACC))
    else $error("access ended while wait sampled");
  halt_hold_a: assert property (
    (core_st_q == CORE_RUN) && sync2_q.halt |=> $stable(pc_q))
    else $error("counter moved while halted");
  irq_prio_a: assert property (
    take && pend_q[0] |=> prog_rd && (prog_addr == `DEB_VEC_IRQ0))
    else $error("request zero not served first");
  irq_low_a: assert property (
    take && (pend_q == 3'h4)
    |=> prog_rd && (prog_addr == `DEB_VEC_IRQ2))
    else $error("wrong vector for request two");
  irq_edge_a: assert property (
    ce && irq_rise[1] |=> pend_q[1])
    else $error("rising edge not latched");
  boot_fetch_a: assert property (
    ce && (core_st_q == CORE_BOOT)
    |=> prog_rd && (prog_addr == `DEB_VEC_RST)
        && (core_st_q == CORE_LOAD))
    else $error("reset vector not fetched");
  stat_clear_a: assert property (
    @(posedge aclk) disable iff (1'b0)
    !aresetn |=> (stat_v == 32'h0000_0000))
    else $error("status not cleared by reset");
  uout_pin_a: assert property (
    ce && wr_stat |=> user_out_zero == !$past(w_data_q[0]))
    else $error("user output not inverted status bit");

  ext_write_c: cover property (cmd_go && ext_hit && !cmd_w.rd);
  ext_waited_c: cover property (
    (bus_st_q == BUS_ACC) && !ws_cnt_q && ext_wait);
  irq_taken_c: cover property (take && (pend_q == 3'h3));
  halted_c: cover property ((core_st_q == CORE_RUN) && sync2_q.halt);

endmodule

/* testbench/deb_periph.sv */
// external peripheral registers on the external register bus
// assumes strobe, select and data enable of deb_top; wait length from bench
`timescale 1ns/100ps
module deb_periph (
  input  wire logic        aclk,
  input  wire logic [2:0]  ext_reg_addr,
  input  wire logic        ext_rd_wr,
  input  wire logic        data_strobe_n,
  input  wire logic [15:0] ext_data_out,
  input  wire logic        ext_data_oe_n,
  input  wire logic [3:0]  n_wait,
  output logic [15:0]      ext_data_in,
  output logic             ext_wait
);
  logic [15:0] mem_q [8];
  logic [15:0] last_q = 16'h0000;
  logic [3:0]  cnt_q;

  // resolved bus level; released bus keeps toggling
  always_comb begin
    if (!ext_data_oe_n)
      ext_data_in = ext_data_out;
    else if (!data_strobe_n && ext_rd_wr)
      ext_data_in = mem_q[ext_reg_addr];
    else
      ext_data_in = ~last_q;
  end

  // slow peripheral holds wait for n_wait cycles
  assign ext_wait = !data_strobe_n && (cnt_q < n_wait);

  always_ff @(posedge aclk) begin
    last_q <= ext_data_in;
    cnt_q <= data_strobe_n ? 4'h0 : cnt_q + 4'h1;
    if (!data_strobe_n && !ext_rd_wr)
      mem_q[ext_reg_addr] <= ext_data_in;
  end
endmodule

/* testbench/tb.sv */
// self-checking bench for deb_top with external peripheral model
// assumes deb_pkg and deb_params.svh on the include path
`timescale 1ns/100ps
`include "deb_params.svh"
module tb
  import deb_pkg::*;
;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hf, n_wait = 4'h0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, branch_cond, rsp;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0,
               s_axi_bready = 1'h0, s_axi_arvalid = 1'h0,
               s_axi_rready = 1'h0, aresetn = 1'h0, ce = 1'h1,
               halt = 1'h1, irq_high_prio = 1'h0, irq_mid_prio = 1'h0,
               irq_low_prio = 1'h0, user_in_zero = 1'h0,
               user_in_one = 1'h0;
  logic        aclk, s_axi_awready, s_axi_wready, s_axi_bvalid,
               s_axi_arready, s_axi_rvalid, ext_rd_wr, data_strobe_n,
               ext_data_oe_n, ext_wait, user_out_zero, user_out_one,
               prog_rd;
  logic [2:0]  ext_reg_addr, str_addr;
  logic [15:0] ext_data_out, ext_data_in;
  logic [11:0] prog_addr, prog_data = 12'h123;
  int          num_errors, cmp_count, str_cnt, k;

  deb_top i_dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_reg_addr, .ext_rd_wr,
    .data_strobe_n, .ext_data_out, .ext_data_in, .ext_data_oe_n, .ext_wait,
    .halt, .irq_high_prio, .irq_mid_prio, .irq_low_prio, .user_in_zero,
    .user_in_one, .user_out_zero, .user_out_one, .branch_cond, .prog_addr,
    .prog_rd, .prog_data);
  deb_periph i_per (.aclk, .ext_reg_addr, .ext_rd_wr, .data_strobe_n,
    .ext_data_out, .ext_data_oe_n, .n_wait, .ext_data_in, .ext_wait);

  initial begin
    aclk = 1'h0;
    forever #2 aclk = ~aclk;
  end

  // ----
  // helpers
  // ----
  task print_verdict;
    if (num_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task tmo;
    num_errors++;
    $display("mismatch at %0t: no answer", $time);
    print_verdict();
  endtask

  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    if (n == 50) tmo();
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task axi_rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    if (n == 50) tmo();
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  task chk_reg(input logic [7:0] a, input logic [31:0] m,
               input logic [31:0] e);
    axi_rd(a);
    chk(rd & m, e, "register");
  endtask

  task wait_fetch(input logic [11:0] e);
    int n;
    for (n = 0; n < 60; n++) begin
      @(negedge aclk);
      if (prog_rd === 1'h1) break;
    end
    if (n == 60) tmo();
    chk(prog_addr, e, "fetch address");
  endtask

  task ext_acc(input logic [2:0] s, input logic r, input logic [15:0] d,
               input int len, input logic [15:0] e);
    deb_cmd_s c;
    int n;
    c = '{rd: r, addr: s, data: d};
    str_cnt = 0;
    axi_wr(`DEB_OFF_CMD, {12'h000, c});
    for (n = 0; n < 50; n++) begin
      axi_rd(`DEB_OFF_CMD);
      if (rd[16] === 1'h0) break;
    end
    if (n == 50) tmo();
    chk(str_cnt, len, "strobe cycles");
    if (len > 0) chk(str_addr, s, "slot");
    chk(ext_reg_addr, s, "address");
    if (r) chk(rd[15:0], e, "read data");
  endtask

  // strobe watcher and data enable check
  always @(negedge aclk) begin
    if (!data_strobe_n) begin
      str_cnt++;
      str_addr = ext_reg_addr;
    end
    if (!ext_data_oe_n && (data_strobe_n || ext_rd_wr))
      chk(1, 0, "bus driven");
  end

  // ----
  // scenarios
  // ----
  task t_boot;
    wait_fetch(12'hFFC);
    chk_reg(`DEB_OFF_STAT, 32'h0000_01D3, 32'h0000_0000);
    repeat (4) @(posedge aclk);
    chk_reg(`DEB_OFF_PC, 32'h0000_0FFF, 32'h0000_0123);
  endtask

  task t_user;
    for (k = 0; k < 4; k++) begin
      axi_wr(`DEB_OFF_STAT, k);
      @(negedge aclk);
      chk({user_out_one, user_out_zero}, {~k[1], ~k[0]}, "user out");
      chk_reg(`DEB_OFF_STAT, 32'h0000_0003, k);
    end
    user_in_one <= 1'h1;
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    chk(branch_cond, 2'h2, "branch inputs");
    chk_reg(`DEB_OFF_STAT, 32'h0000_000C, 32'h0000_0008);
  endtask

  task t_rst2;
    @(posedge aclk);
    aresetn <= 1'h0;
    prog_data <= 12'h456;
    @(posedge aclk);
    aresetn <= 1'h1;
    wait_fetch(12'hFFC);
    chk({user_out_one, user_out_zero}, 2'h3, "user out");
    chk_reg(`DEB_OFF_PC, 32'h0FFF_0FFF, 32'h0123_0456);
  endtask

  task t_ext;
    axi_wr(`DEB_OFF_CTRL, 32'h0000_0000);
    for (k = 0; k < 4; k++) begin
      ext_acc(k, 0, 16'hA5A0 + k, 1, 0);
      ext_acc(k, 1, 0, 1, 16'hA5A0 + k);
    end
    ext_acc(3'h4, 1, 0, 0, 0);
    ext_acc(3'h7, 0, 16'h1234, 0, 0);
    axi_wr(`DEB_OFF_CTRL, 32'h0000_0002);
    ext_acc(3'h5, 0, 16'h5A5A, 1, 0);
    ext_acc(3'h5, 1, 0, 1, 16'h5A5A);
    n_wait <= 4'h3;
    ext_acc(3'h2, 1, 0, 4, 16'hA5A2);
    n_wait <= 4'h0;
    axi_wr(`DEB_OFF_CTRL, 32'h0000_0001);
    ext_acc(3'h1, 1, 0, 2, 16'hA5A1);
    n_wait <= 4'h3;
    axi_wr(`DEB_OFF_CTRL, 32'h0000_0000);
    ext_acc(3'h0, 0, 16'h0F0F, 4, 0);
    axi_rd(8'h10);
    chk(rsp, `DEB_RESP_SLV, "unmapped read");
    axi_wr(`DEB_OFF_PC, 32'h0000_0000);
    chk(rsp, `DEB_RESP_SLV, "pc write");
  endtask

  task t_irq;
    irq_high_prio <= 1'h1;
    irq_mid_prio <= 1'h1;
    irq_low_prio <= 1'h1;
    repeat (6) @(posedge aclk);
    chk_reg(`DEB_OFF_STAT, 32'h0000_01C0, 32'h0000_01C0);
    halt <= 1'h0;
    wait_fetch(12'hFFF);
    wait_fetch(12'hFFE);
    wait_fetch(12'hFFD);
    repeat (10) @(posedge aclk);
    chk_reg(`DEB_OFF_STAT, 32'h0000_01C0, 32'h0000_0000);
  endtask

  // five frozen edges between two reads add nothing to the count
  task t_ce;
    logic [11:0] p;
    axi_rd(`DEB_OFF_PC);
    p = rd[11:0] + 12'h3;
    ce <= 1'h0;
    repeat (5) @(posedge aclk);
    ce <= 1'h1;
    axi_rd(`DEB_OFF_PC);
    chk(rd[11:0], p, "frozen counter");
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    t_boot();
    t_user();
    axi_wr(`DEB_OFF_STAT, 32'h0000_0003);
    t_rst2();
    t_ext();
    t_irq();
    t_ce();
    print_verdict();
  end
endmodule
